// ### src/sensor_irq_control.sv
module sensor_irq_control (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // register port
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // measurement events
  input wire sensor_irq_pkg::meas_t prox_meas_in [sensor_irq_pkg::PROX_CHANNELS],
  input wire logic [sensor_irq_pkg::MEAS_W-1:0] prox_threshold_in [sensor_irq_pkg::PROX_CHANNELS],
  input wire sensor_irq_pkg::meas_t visible_channel_in,
  input wire sensor_irq_pkg::meas_t infrared_channel_in,
  input wire logic [sensor_irq_pkg::MEAS_W-1:0] light_low_threshold_in,
  input wire logic [sensor_irq_pkg::MEAS_W-1:0] light_high_threshold_in,
  input wire logic cmd_event_in,
  // interrupt pin
  output logic irq_pin_out,
  output logic irq_pin_oe_out
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] irq_cfg_reg;
  logic [7:0] irq_enable_reg;
  logic [7:0] irq_select_reg_a;
  logic [7:0] irq_flag_reg;
  logic [7:0] irq_flag_next;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic [7:0] rdata_reg;
  logic oe_reg;
  logic irq_pin_drive_en;
  logic status_clear_mode;
  logic [1:0] light_flag_en;
  logic [2:0] light_trigger_sel;
  logic [1:0] proxn_trigger_sel [sensor_irq_pkg::PROX_CHANNELS];
  logic [sensor_irq_pkg::PROX_CHANNELS-1:0] prox_above;
  logic [sensor_irq_pkg::PROX_CHANNELS-1:0] prev_above_reg;
  logic [sensor_irq_pkg::PROX_CHANNELS-1:0] prox_set;
  logic [sensor_irq_pkg::PROX_CHANNELS-1:0] prox_auto_clr;
  logic vis_inside;
  logic ir_inside;
  logic prev_vis_inside_reg;
  logic prev_ir_inside_reg;
  logic light_lo_set;
  logic light_hi_set;
  logic wr_cfg;
  logic wr_enable;
  logic wr_select;
  logic wr_flags;

  assign irq_pin_drive_en = irq_cfg_reg[sensor_irq_pkg::CFG_DRIVE_BIT];
  assign status_clear_mode = irq_cfg_reg[sensor_irq_pkg::CFG_CLEAR_MODE_BIT];
  assign light_flag_en = irq_enable_reg[sensor_irq_pkg::LIGHT_HI_BIT:sensor_irq_pkg::LIGHT_LO_BIT];
  assign light_trigger_sel = irq_select_reg_a[sensor_irq_pkg::SEL_LIGHT_LSB +: 3];
  assign proxn_trigger_sel[0] = irq_select_reg_a[sensor_irq_pkg::SEL_PROX1_LSB +: 2];
  assign proxn_trigger_sel[1] = irq_select_reg_a[sensor_irq_pkg::SEL_PROX2_LSB +: 2];
  assign proxn_trigger_sel[2] = sensor_irq_pkg::TRIG_DONE;

  assign wr_cfg = reg_wr_in && (reg_addr_in == sensor_irq_pkg::ADDR_IRQ_PIN_CONFIG);
  assign wr_enable = reg_wr_in && (reg_addr_in == sensor_irq_pkg::ADDR_IRQ_SOURCE_ENABLE);
  assign wr_select = reg_wr_in && (reg_addr_in == sensor_irq_pkg::ADDR_IRQ_TRIGGER_SELECT_A);
  assign wr_flags = reg_wr_in && (reg_addr_in == sensor_irq_pkg::ADDR_IRQ_FLAGS);

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_cfg_reg <= sensor_irq_pkg::REG_RESET;
      irq_enable_reg <= sensor_irq_pkg::REG_RESET;
      irq_select_reg_a <= sensor_irq_pkg::REG_RESET;
    end else begin
      if (wr_cfg) begin
        irq_cfg_reg <= reg_wdata_in & sensor_irq_pkg::CONFIG_MASK;
      end
      if (wr_enable) begin
        irq_enable_reg <= reg_wdata_in & sensor_irq_pkg::ENABLE_MASK;
      end
      if (wr_select) begin
        irq_select_reg_a <= reg_wdata_in & sensor_irq_pkg::SELECT_MASK;
      end
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_reg <= sensor_irq_pkg::RDATA_UNMAPPED;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        sensor_irq_pkg::ADDR_IRQ_PIN_CONFIG: rdata_reg <= irq_cfg_reg;
        sensor_irq_pkg::ADDR_IRQ_SOURCE_ENABLE: rdata_reg <= irq_enable_reg;
        sensor_irq_pkg::ADDR_IRQ_TRIGGER_SELECT_A: rdata_reg <= irq_select_reg_a;
        sensor_irq_pkg::ADDR_IRQ_FLAGS: rdata_reg <= irq_flag_reg;
        default: rdata_reg <= sensor_irq_pkg::RDATA_UNMAPPED;
      endcase
    end
  end
  assign reg_rdata_out = rdata_reg;

  // ---------------------------------------------------------------
  // proximity channels
  // ---------------------------------------------------------------
  for (genvar i = 0; i < sensor_irq_pkg::PROX_CHANNELS; i++) begin : g_prox
    logic chan_en;
    assign chan_en = irq_enable_reg[sensor_irq_pkg::PROX1_BIT + i];
    assign prox_above[i] = prox_meas_in[i].value > prox_threshold_in[i];
    always_comb begin
      prox_set[i] = 1'b0;
      if (chan_en && prox_meas_in[i].valid) begin
        case (proxn_trigger_sel[i])
          sensor_irq_pkg::TRIG_DONE: prox_set[i] = 1'b1;
          sensor_irq_pkg::TRIG_CROSS: prox_set[i] = prox_above[i] != prev_above_reg[i];
          sensor_irq_pkg::TRIG_ABOVE: prox_set[i] = prox_above[i];
          default: prox_set[i] = 1'b0;
        endcase
      end
    end
    // self release in clear mode 1 with trigger 11
    assign prox_auto_clr[i] = status_clear_mode && chan_en && prox_meas_in[i].valid &&
        (proxn_trigger_sel[i] == sensor_irq_pkg::TRIG_ABOVE) && !prox_above[i];
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        prev_above_reg[i] <= 1'b0;
      end else if (prox_meas_in[i].valid) begin
        prev_above_reg[i] <= prox_above[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // light channel
  // ---------------------------------------------------------------
  assign vis_inside = (visible_channel_in.value >= light_low_threshold_in) &&
      (visible_channel_in.value <= light_high_threshold_in);
  assign ir_inside = (infrared_channel_in.value >= light_low_threshold_in) &&
      (infrared_channel_in.value <= light_high_threshold_in);

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prev_vis_inside_reg <= 1'b0;
      prev_ir_inside_reg <= 1'b0;
    end else begin
      if (visible_channel_in.valid) begin
        prev_vis_inside_reg <= vis_inside;
      end
      if (infrared_channel_in.valid) begin
        prev_ir_inside_reg <= ir_inside;
      end
    end
  end

  // enable 00 blocks both bits
  always_comb begin
    light_lo_set = 1'b0;
    light_hi_set = 1'b0;
    if (light_flag_en[0]) begin
      if (light_trigger_sel == sensor_irq_pkg::LIGHT_SEL_EVERY) begin
        light_lo_set = !light_flag_en[1] && visible_channel_in.valid;
      end else if (light_trigger_sel[1:0] == sensor_irq_pkg::LIGHT_LO_VIS) begin
        light_lo_set = visible_channel_in.valid && prev_vis_inside_reg && !vis_inside;
      end else if (light_trigger_sel[1:0] == sensor_irq_pkg::LIGHT_LO_IR) begin
        light_lo_set = infrared_channel_in.valid && prev_ir_inside_reg && !ir_inside;
      end
    end
    if (light_flag_en[1]) begin
      if (light_trigger_sel[2:1] == sensor_irq_pkg::LIGHT_HI_VIS) begin
        light_hi_set = visible_channel_in.valid && !prev_vis_inside_reg && vis_inside;
      end else if (light_trigger_sel[2:1] == sensor_irq_pkg::LIGHT_HI_IR) begin
        light_hi_set = infrared_channel_in.valid && !prev_ir_inside_reg && ir_inside;
      end
    end
  end

  // ---------------------------------------------------------------
  // sticky flags
  // ---------------------------------------------------------------
  always_comb begin
    flag_set = 8'h00;
    flag_set[sensor_irq_pkg::LIGHT_LO_BIT] = light_lo_set;
    flag_set[sensor_irq_pkg::LIGHT_HI_BIT] = light_hi_set;
    flag_set[sensor_irq_pkg::PROX1_BIT +: sensor_irq_pkg::PROX_CHANNELS] = prox_set;
    flag_set[sensor_irq_pkg::CMD_BIT] = cmd_event_in;
    flag_clr = 8'h00;
    flag_clr[sensor_irq_pkg::PROX1_BIT +: sensor_irq_pkg::PROX_CHANNELS] = prox_auto_clr;
    if (wr_flags) begin
      flag_clr = flag_clr | reg_wdata_in;
    end
    // set wins over clear
    irq_flag_next = ((irq_flag_reg & ~flag_clr) | flag_set) & sensor_irq_pkg::FLAGS_MASK;
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_flag_reg <= sensor_irq_pkg::REG_RESET;
    end else begin
      irq_flag_reg <= irq_flag_next;
    end
  end

  // ---------------------------------------------------------------
  // interrupt pin
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= irq_pin_drive_en && |(irq_flag_reg & irq_enable_reg);
    end
  end
  assign irq_pin_oe_out = oe_reg;
  assign irq_pin_out = 1'b0;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence pending_s;
    irq_pin_drive_en && |(irq_flag_reg & irq_enable_reg);
  endsequence
  sequence clear_write_s;
    wr_flags && !cmd_event_in && reg_wdata_in[sensor_irq_pkg::CMD_BIT];
  endsequence

  drive_off_a: assert property (!irq_pin_drive_en |=> !irq_pin_oe_out)
    else $error("irq pin driven while drive disabled");
  drive_on_a: assert property (pending_s |=> irq_pin_oe_out)
    else $error("irq pin not driven with pending flag");
  sequence prox1_above_s;
    prox_meas_in[0].valid && irq_enable_reg[sensor_irq_pkg::PROX1_BIT] &&
        proxn_trigger_sel[0] == sensor_irq_pkg::TRIG_ABOVE &&
        prox_meas_in[0].value > prox_threshold_in[0];
  endsequence

  cmd_gate_a: assert property (!irq_enable_reg[sensor_irq_pkg::CMD_BIT] &&
      (irq_flag_reg & irq_enable_reg) == 8'h00 |=> !irq_pin_oe_out)
    else $error("irq pin driven with no enabled flag");
  cmd_set_a: assert property (cmd_event_in |=> irq_flag_reg[sensor_irq_pkg::CMD_BIT])
    else $error("command flag not set");
  flag_clear_a: assert property (clear_write_s |=> !irq_flag_reg[sensor_irq_pkg::CMD_BIT])
    else $error("flag not cleared by write of one");
  flag_sticky_a: assert property (irq_flag_reg[sensor_irq_pkg::CMD_BIT] && !wr_flags
      |=> irq_flag_reg[sensor_irq_pkg::CMD_BIT])
    else $error("flag dropped without clear");
  prox_done_a: assert property (prox_meas_in[0].valid &&
      irq_enable_reg[sensor_irq_pkg::PROX1_BIT] &&
      proxn_trigger_sel[0] == sensor_irq_pkg::TRIG_DONE
      |=> irq_flag_reg[sensor_irq_pkg::PROX1_BIT])
    else $error("prox flag not set on completion");
  prox_disabled_a: assert property (!irq_enable_reg[sensor_irq_pkg::PROX1_BIT] &&
      !irq_flag_reg[sensor_irq_pkg::PROX1_BIT] |=> !irq_flag_reg[sensor_irq_pkg::PROX1_BIT])
    else $error("prox flag set while channel disabled");
  auto_release_a: assert property (prox_auto_clr[0] && !wr_flags
      |=> !irq_flag_reg[sensor_irq_pkg::PROX1_BIT])
    else $error("prox flag not released automatically");
  light_off_a: assert property (light_flag_en == 2'b00 &&
      irq_flag_reg[sensor_irq_pkg::LIGHT_HI_BIT:sensor_irq_pkg::LIGHT_LO_BIT] == 2'b00
      |=> irq_flag_reg[sensor_irq_pkg::LIGHT_HI_BIT:sensor_irq_pkg::LIGHT_LO_BIT] == 2'b00)
    else $error("light flag set while light disabled");
  prox_above_a: assert property (prox1_above_s |=> irq_flag_reg[sensor_irq_pkg::PROX1_BIT])
    else $error("prox flag not set above threshold");
  prox_cross_a: assert property (prox_meas_in[1].valid &&
      irq_enable_reg[sensor_irq_pkg::PROX1_BIT + 1] &&
      proxn_trigger_sel[1] == sensor_irq_pkg::TRIG_CROSS &&
      (prox_meas_in[1].value > prox_threshold_in[1]) != prev_above_reg[1]
      |=> irq_flag_reg[sensor_irq_pkg::PROX1_BIT + 1])
    else $error("prox flag not set on threshold crossing");
  light_every_a: assert property (light_flag_en == 2'b01 &&
      light_trigger_sel == sensor_irq_pkg::LIGHT_SEL_EVERY && visible_channel_in.valid
      |=> irq_flag_reg[sensor_irq_pkg::LIGHT_LO_BIT])
    else $error("light flag not set on visible sample");
  light_hi_off_a: assert property (!light_flag_en[1] &&
      !irq_flag_reg[sensor_irq_pkg::LIGHT_HI_BIT]
      |=> !irq_flag_reg[sensor_irq_pkg::LIGHT_HI_BIT])
    else $error("upper light flag set while disabled");

endmodule

// ### common/sensor_irq_pkg.sv
package sensor_irq_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_IRQ_PIN_CONFIG = 8'h03;
  localparam logic [7:0] ADDR_IRQ_SOURCE_ENABLE = 8'h04;
  localparam logic [7:0] ADDR_IRQ_TRIGGER_SELECT_A = 8'h05;
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h21;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // ---------------------------------------------------------------
  // writable bit masks, reserved bits read zero
  // ---------------------------------------------------------------
  localparam logic [7:0] CONFIG_MASK = 8'h03;
  localparam logic [7:0] ENABLE_MASK = 8'h3f;
  localparam logic [7:0] SELECT_MASK = 8'hf7;
  localparam logic [7:0] FLAGS_MASK = 8'h3f;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CFG_DRIVE_BIT = 0;
  localparam int CFG_CLEAR_MODE_BIT = 1;
  localparam int LIGHT_LO_BIT = 0;
  localparam int LIGHT_HI_BIT = 1;
  localparam int PROX1_BIT = 2;
  localparam int CMD_BIT = 5;
  localparam int PROX_CHANNELS = 3;
  localparam int SEL_PROX1_LSB = 4;
  localparam int SEL_PROX2_LSB = 6;
  localparam int SEL_LIGHT_LSB = 0;

  // ---------------------------------------------------------------
  // trigger encodings
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    TRIG_DONE = 2'b00,
    TRIG_CROSS = 2'b01,
    TRIG_RSVD = 2'b10,
    TRIG_ABOVE = 2'b11
  } prox_trig_t;
  localparam logic [2:0] LIGHT_SEL_EVERY = 3'h0;
  localparam logic [1:0] LIGHT_LO_VIS = 2'h1;
  localparam logic [1:0] LIGHT_LO_IR = 2'h3;
  localparam logic [1:0] LIGHT_HI_VIS = 2'h2;
  localparam logic [1:0] LIGHT_HI_IR = 2'h3;

  // ---------------------------------------------------------------
  // measurement carrier
  // ---------------------------------------------------------------
  localparam int MEAS_W = 16;
  typedef struct packed {
    logic valid;
    logic [MEAS_W-1:0] value;
  } meas_t;

endpackage

// ### test/sensor_host_model.sv
module sensor_host_model (
  // clock
  input wire logic sys_clk_in,
  // register port toward the device
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  input wire logic [7:0] reg_rdata_in,
  // interrupt pin
  input wire logic irq_pin_in,
  input wire logic irq_pin_oe_in,
  output logic irq_level_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // -------------------------------------------------------------
  // pin level with external pull-up
  // -------------------------------------------------------------
  assign irq_level_out = irq_pin_oe_in ? irq_pin_in : 1'b1;

  initial begin
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
  end

  // -------------------------------------------------------------
  // register cycles
  // -------------------------------------------------------------
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge sys_clk_in);
    #1;
    reg_wr_out = 1'b1;
    reg_addr_out = addr;
    reg_wdata_out = data;
    @(posedge sys_clk_in);
    #1;
    reg_wr_out = 1'b0;
    reg_addr_out = ~addr;
    reg_wdata_out = ~data;
  endtask

  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(posedge sys_clk_in);
    #1;
    reg_rd_out = 1'b1;
    reg_addr_out = addr;
    @(posedge sys_clk_in);
    #1;
    reg_rd_out = 1'b0;
    reg_addr_out = ~addr;
    data = reg_rdata_in;
  endtask

  // write-one clear of pending flags
  task automatic clear_flags(input logic [7:0] mask);
    wr(8'h21, mask);
  endtask
endmodule

// ### test/test_sensor_irq_control.sv
module test_sensor_irq_control;
  timeunit 1ns;
  timeprecision 100ps;

  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic reg_wr, reg_rd, cmd_event, irq_pin, irq_pin_oe, irq_level;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  sensor_irq_pkg::meas_t prox_meas [sensor_irq_pkg::PROX_CHANNELS];
  logic [15:0] prox_thr [sensor_irq_pkg::PROX_CHANNELS];
  sensor_irq_pkg::meas_t vis_ch, ir_ch;
  logic [15:0] low_thr, high_thr;
  int error_cnt = 0;
  int comparisons = 0;

  always #50 sys_clk = ~sys_clk;

  sensor_irq_control i_sensor_irq_control (
    .sys_clk_in(sys_clk), .reset_n_in(reset_n), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata),
    .prox_meas_in(prox_meas), .prox_threshold_in(prox_thr), .visible_channel_in(vis_ch),
    .infrared_channel_in(ir_ch), .light_low_threshold_in(low_thr),
    .light_high_threshold_in(high_thr), .cmd_event_in(cmd_event),
    .irq_pin_out(irq_pin), .irq_pin_oe_out(irq_pin_oe));

  sensor_host_model i_sensor_host_model (
    .sys_clk_in(sys_clk), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd), .reg_addr_out(reg_addr),
    .reg_wdata_out(reg_wdata), .reg_rdata_in(reg_rdata), .irq_pin_in(irq_pin),
    .irq_pin_oe_in(irq_pin_oe), .irq_level_out(irq_level));

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic creg(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    i_sensor_host_model.rd(addr, d);
    check($sformatf("reg %h", addr), d, exp);
  endtask

  task automatic pin(input logic exp);
    repeat (2) @(posedge sys_clk);
    #1;
    check("irq level", {7'h00, irq_level}, {7'h00, exp});
  endtask

  task automatic set3(input logic [7:0] cfg, input logic [7:0] en, input logic [7:0] sel);
    i_sensor_host_model.wr(8'h03, cfg);
    i_sensor_host_model.wr(8'h04, en);
    i_sensor_host_model.wr(8'h05, sel);
    i_sensor_host_model.clear_flags(8'h3f);
  endtask

  // kinds: 0..2 proximity, 3 visible, 4 infrared, 5 command
  task automatic ev(input int k, input logic [15:0] v);
    @(posedge sys_clk);
    #1;
    case (k)
      3: vis_ch = '{1'b1, v};
      4: ir_ch = '{1'b1, v};
      5: cmd_event = 1'b1;
      default: prox_meas[k] = '{1'b1, v};
    endcase
    @(posedge sys_clk);
    #1;
    vis_ch.valid = 1'b0;
    ir_ch.valid = 1'b0;
    cmd_event = 1'b0;
    foreach (prox_meas[i]) prox_meas[i].valid = 1'b0;
  endtask

  task automatic finish_test();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_regs();
    creg(8'h03, 8'h00);
    creg(8'h04, 8'h00);
    creg(8'h05, 8'h00);
    creg(8'h21, 8'h00);
    creg(8'h10, 8'h00);
    set3(8'hff, 8'hff, 8'hff);
    creg(8'h03, 8'h03);
    creg(8'h04, 8'h3f);
    creg(8'h05, 8'hf7);
  endtask

  task automatic t_sticky();
    set3(8'h01, 8'h04, 8'h00);
    ev(0, 16'h0005);
    pin(1'b0);
    check("pin out", {7'h00, irq_pin}, 8'h00);
    creg(8'h21, 8'h04);
    repeat (5) @(posedge sys_clk);
    i_sensor_host_model.wr(8'h21, 8'h00);
    creg(8'h21, 8'h04);
    i_sensor_host_model.clear_flags(8'h04);
    pin(1'b1);
    set3(8'h00, 8'h04, 8'h00);
    ev(0, 16'h0005);
    pin(1'b1);
    creg(8'h21, 8'h04);
  endtask

  task automatic t_gates();
    set3(8'h01, 8'h00, 8'h00);
    ev(5, 16'h0000);
    pin(1'b1);
    i_sensor_host_model.wr(8'h04, 8'h20);
    pin(1'b0);
    set3(8'h01, 8'h00, 8'h00);
    ev(1, 16'h0005);
    creg(8'h21, 8'h00);
    i_sensor_host_model.wr(8'h04, 8'h10);
    ev(2, 16'h0005);
    pin(1'b0);
    set3(8'h01, 8'h00, 8'h00);
    ev(3, 16'h0005);
    creg(8'h21, 8'h00);
    i_sensor_host_model.wr(8'h04, 8'h01);
    ev(3, 16'h0005);
    pin(1'b0);
    creg(8'h21, 8'h01);
    i_sensor_host_model.wr(8'h04, 8'h02);
    pin(1'b1);
  endtask

  task automatic t_prox_modes();
    set3(8'h03, 8'h04, 8'h30);
    ev(0, 16'd50);
    creg(8'h21, 8'h00);
    ev(0, 16'd150);
    pin(1'b0);
    ev(0, 16'd50);
    pin(1'b1);
    set3(8'h01, 8'h08, 8'h40);
    ev(1, 16'd150);
    creg(8'h21, 8'h08);
    i_sensor_host_model.clear_flags(8'h08);
    ev(1, 16'd200);
    creg(8'h21, 8'h00);
    ev(1, 16'd50);
    creg(8'h21, 8'h08);
  endtask

  task automatic t_window();
    set3(8'h01, 8'h03, 8'h01);
    ev(3, 16'd150);
    ev(3, 16'd250);
    creg(8'h21, 8'h01);
    set3(8'h01, 8'h03, 8'h04);
    ev(3, 16'd150);
    creg(8'h21, 8'h02);
    set3(8'h01, 8'h03, 8'h03);
    ev(4, 16'd150);
    ev(4, 16'd250);
    creg(8'h21, 8'h01);
    set3(8'h01, 8'h03, 8'h06);
    ev(4, 16'd150);
    creg(8'h21, 8'h02);
  endtask

  // -------------------------------------------------------------
  // main sequence and watchdog
  // -------------------------------------------------------------
  initial begin
    cmd_event = 1'b0;
    vis_ch = '0;
    ir_ch = '0;
    low_thr = 16'd100;
    high_thr = 16'd200;
    foreach (prox_meas[i]) prox_meas[i] = '0;
    foreach (prox_thr[i]) prox_thr[i] = 16'd100;
    repeat (2) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    t_regs();
    t_sticky();
    t_gates();
    t_prox_modes();
    t_window();
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    finish_test();
  end
endmodule
